// ---- shift_flag_unit.v ----
/*
 * shift and flag datapath slice: register shifts with carry effects,
 * and-based test, zero extension, narrow store data, link and branch
 * target bit-0 handling, and the held n/z/c/v condition flags.
 * assumes one instruction per op_valid pulse from the decoder, operands
 * already read from the register file, and a synchronous active-low reset.
 */
//
// Overview of operation
// - zero length passes value, keeps carry
// - arithmetic right fills top with sign
// - flagged arithmetic right carry is bit n-1
// - length 32 or more clears result, except rotate
// - length 33 or more clears carry, except rotate
// - logical right fills top with zeros
// - flagged logical right carry is bit n-1
// - logical left fills bottom with zeros
// - flagged logical left carry is bit 32-n
// - link register value gets bit0 forced
// - and-test sets only negative and zero
// - zero extend byte/half, flags unchanged
// - narrow stores write low bits only
// - rotate right wraps low bits to top
// - flagged rotate carry is bit n-1
// - flags not updated keep old value
//
`timescale 1ns/1ps
`include "shift_flag_defs.vh"

module shift_flag_unit
(
    input  wire                clk_sys,            // core clock, 25 MHz
    input  wire                rst_n,              // synchronous reset, active low
    input  wire                op_valid,           // one-cycle instruction strobe
    input  wire [`OP_W-1:0]    op_code,            // operation select
    input  wire                set_flags,          // flagged variant of a shift
    input  wire [`WORD_W-1:0]  operand_m,          // shifted / extended / stored source
    input  wire [`WORD_W-1:0]  operand_n,          // second and-test operand
    input  wire [`SHAMT_W-1:0] shift_len,          // shift length n
    input  wire [`WORD_W-1:0]  return_addr,        // return address for link
    input  wire                flags_load,         // restore flags from flags_in
    input  wire [3:0]          flags_in,           // n z c v to restore
    output reg  [`WORD_W-1:0]  result,             // register-file write data
    output reg                 result_write,       // pulse: write result
    output reg  [`WORD_W-1:0]  store_data,         // memory write data
    output reg  [3:0]          store_strobe,       // byte lanes written
    output reg                 store_write,        // pulse: narrow store
    output reg  [`WORD_W-1:0]  link_value,         // link register write data
    output reg                 link_write,         // pulse: write link register
    output reg  [`WORD_W-1:0]  branch_target,      // new program counter
    output reg                 branch_write,       // pulse: load program counter
    output reg                 branch_state_fault, // pulse: target bit0 was clear
    output reg                 flag_n,             // negative flag
    output reg                 flag_z,             // zero flag
    output reg                 flag_c,             // carry flag
    output reg                 flag_v              // overflow flag
);

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire                is_shift;       // any of the four shifts
    wire                is_zext;        // zero extension
    wire                is_store;       // narrow store
    wire                is_link;        // writes the link register
    wire                is_indirect;    // target from a register
    wire [`WORD_W-1:0]  shift_result;   // shifter output
    wire                shift_carry;    // shifter carry
    wire                shift_carry_upd;// shifter says carry changes
    wire [`WORD_W-1:0]  and_result;     // discarded and-test value

    assign is_shift    = (op_code == `OP_ASR) || (op_code == `OP_LSR)
                       || (op_code == `OP_LSL) || (op_code == `OP_ROR);
    assign is_zext     = (op_code == `OP_ZEXT_BYTE) || (op_code == `OP_ZEXT_HALF);
    assign is_store    = (op_code == `OP_STORE_BYTE) || (op_code == `OP_STORE_HALF);
    assign is_link     = (op_code == `OP_BRANCH_LINK) || (op_code == `OP_BRANCH_IND_L);
    assign is_indirect = (op_code == `OP_BRANCH_IND) || (op_code == `OP_BRANCH_IND_L);
    assign and_result  = operand_n & operand_m;

    // ----------------------------------------------------------------
    // shifter
    // ----------------------------------------------------------------
    barrel_shifter u_shifter
    (
        .operand      (operand_m),
        .shift_len    (shift_len),
        .shift_kind   (op_code),
        .shifted      (shift_result),
        .carry_out    (shift_carry),
        .carry_update (shift_carry_upd)
    );

    // ----------------------------------------------------------------
    // next values
    // ----------------------------------------------------------------
    reg [`WORD_W-1:0] next_result;      // register write data
    reg               next_result_write;
    reg [`WORD_W-1:0] next_store_data;  // store data, low lanes only
    reg [3:0]         next_store_strobe;
    reg               next_store_write;
    reg               next_link_write;
    reg               next_branch_write;
    reg               next_fault;
    reg               next_n;
    reg               next_z;
    reg               next_c;
    reg               next_v;

    // per-instruction result and flag selection
    always @*
    begin
        next_result       = result;
        next_result_write = 1'b0;
        next_store_data   = store_data;
        next_store_strobe = `LANE_NONE;
        next_store_write  = 1'b0;
        next_link_write   = 1'b0;
        next_branch_write = 1'b0;
        next_fault        = 1'b0;
        // every flag holds unless an instruction defines it
        next_n            = flag_n;
        next_z            = flag_z;
        next_c            = flag_c;
        next_v            = flag_v;
        if (flags_load)
        begin
            // explicit restore of the status flags
            next_n = flags_in[3];
            next_z = flags_in[2];
            next_c = flags_in[1];
            next_v = flags_in[0];
        end
        else if (op_valid)
        begin
            if (is_shift)
            begin
                next_result       = shift_result;
                next_result_write = 1'b1;
                if (set_flags)
                begin
                    next_n = shift_result[`SIGN_BIT];
                    next_z = (shift_result == `WORD_ZERO);
                    if (shift_carry_upd)
                    begin
                        next_c = shift_carry;
                    end
                end
            end
            else if (op_code == `OP_AND_TEST)
            begin
                // result discarded, carry and overflow kept
                next_n = and_result[`SIGN_BIT];
                next_z = (and_result == `WORD_ZERO);
            end
            else if (is_zext)
            begin
                // flags untouched by extension
                next_result       = (op_code == `OP_ZEXT_BYTE)
                                  ? (operand_m & `BYTE_MASK)
                                  : (operand_m & `HALF_MASK);
                next_result_write = 1'b1;
            end
            else if (is_store)
            begin
                // only the low lanes carry data; flags untouched
                next_store_data   = (op_code == `OP_STORE_BYTE)
                                  ? (operand_m & `BYTE_MASK)
                                  : (operand_m & `HALF_MASK);
                next_store_strobe = (op_code == `OP_STORE_BYTE)
                                  ? `LANE_BYTE : `LANE_HALF;
                next_store_write  = 1'b1;
            end
            if (is_link)
            begin
                next_link_write = 1'b1;
            end
            if (is_indirect)
            begin
                next_branch_write = 1'b1;
                // a clear bit0 selects an unsupported instruction set
                next_fault = ~operand_m[0];
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // all outputs and flags held in flip-flops
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            result             <= `WORD_ZERO;
            result_write       <= 1'b0;
            store_data         <= `WORD_ZERO;
            store_strobe       <= `LANE_NONE;
            store_write        <= 1'b0;
            link_value         <= `WORD_ZERO;
            link_write         <= 1'b0;
            branch_target      <= `WORD_ZERO;
            branch_write       <= 1'b0;
            branch_state_fault <= 1'b0;
            {flag_n, flag_z, flag_c, flag_v} <= `FLAGS_RESET;
        end
        else
        begin
            result             <= next_result;
            result_write       <= next_result_write;
            store_data         <= next_store_data;
            store_strobe       <= next_store_strobe;
            store_write        <= next_store_write;
            link_write         <= next_link_write;
            branch_write       <= next_branch_write;
            branch_state_fault <= next_fault;
            flag_n             <= next_n;
            flag_z             <= next_z;
            flag_c             <= next_c;
            flag_v             <= next_v;
            if (op_valid && is_link)
            begin
                // return address always marks the compact set
                link_value <= return_addr | `LINK_BIT0;
            end
            if (op_valid && is_indirect)
            begin
                // target passed as given; fault flags a clear bit0
                branch_target <= operand_m;
            end
        end
    end

endmodule

// ---- shift_flag_defs.vh ----
/*
 * constants for the shift and flag datapath slice: operation codes,
 * word widths, shift-length thresholds and lane masks.
 * assumes it is included by bare name from the design files.
 */
`ifndef SHIFT_FLAG_DEFS_VH
`define SHIFT_FLAG_DEFS_VH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define WORD_W          32
`define SHAMT_W         8
`define OP_W            4
`define ROT_W           5

// ----------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------
`define OP_NONE         4'h0
`define OP_ASR          4'h1
`define OP_LSR          4'h2
`define OP_LSL          4'h3
`define OP_ROR          4'h4
`define OP_AND_TEST     4'h5
`define OP_ZEXT_BYTE    4'h6
`define OP_ZEXT_HALF    4'h7
`define OP_STORE_BYTE   4'h8
`define OP_STORE_HALF   4'h9
`define OP_BRANCH_LINK  4'ha
`define OP_BRANCH_IND   4'hb
`define OP_BRANCH_IND_L 4'hc

// ----------------------------------------------------------------
// shift thresholds and constants
// ----------------------------------------------------------------
`define SHAMT_ZERO      8'h00
`define SHAMT_ONE       8'h01
`define SHAMT_FULL      8'h20
`define SHAMT_CARRY_OFF 8'h21
`define ROT_ZERO        5'h00
`define ROT_FULL        6'h20
`define SIGN_BIT        31
`define WORD_ZERO       32'h0000_0000
`define BYTE_MASK       32'h0000_00ff
`define HALF_MASK       32'h0000_ffff
`define LINK_BIT0       32'h0000_0001
`define LANE_BYTE       4'h1
`define LANE_HALF       4'h3
`define LANE_NONE       4'h0
`define FLAGS_RESET     4'h0

`endif

// ---- barrel_shifter.v ----
/*
 * combinational 32-bit barrel shifter: arithmetic right, logical right,
 * logical left and rotate right, with the carry-out of the last bit moved.
 * assumes the caller registers the outputs and owns the carry flag.
 */
`timescale 1ns/1ps
`include "shift_flag_defs.vh"

module barrel_shifter
(
    input  wire [`WORD_W-1:0]  operand,      // value to shift
    input  wire [`SHAMT_W-1:0] shift_len,    // shift length n
    input  wire [`OP_W-1:0]    shift_kind,   // one of the shift op codes
    output reg  [`WORD_W-1:0]  shifted,      // shifted value
    output reg                 carry_out,    // new carry value
    output reg                 carry_update  // high when carry must change
);

    // ----------------------------------------------------------------
    // intermediate terms
    // ----------------------------------------------------------------
    wire [`SHAMT_W-1:0] len_less_one;        // n-1, index of last bit out
    wire [`ROT_W-1:0]   rot_len;             // rotate length modulo 32
    wire [`ROT_W-1:0]   rot_less_one;        // rotate length minus one
    wire                len_zero;            // n is zero
    wire                len_full;            // n is 32 or more
    wire                len_carry_off;       // n is 33 or more

    assign len_less_one  = shift_len - `SHAMT_ONE;
    assign rot_len       = shift_len[`ROT_W-1:0];
    assign rot_less_one  = rot_len - 5'h01;
    assign len_zero      = (shift_len == `SHAMT_ZERO);
    assign len_full      = (shift_len >= `SHAMT_FULL);
    assign len_carry_off = (shift_len >= `SHAMT_CARRY_OFF);

    // ----------------------------------------------------------------
    // shift network
    // ----------------------------------------------------------------
    // lengths 1..32 take the carry from n-1 (right) or 32-n (left);
    // shifting by n-1 and picking an end bit covers 32 without overflow
    always @*
    begin
        shifted      = operand;
        carry_out    = 1'b0;
        carry_update = 1'b0;
        if (len_zero)
        begin
            // no shift: value through, carry untouched
            shifted      = operand;
            carry_update = 1'b0;
        end
        else
        begin
            case (shift_kind)
                `OP_ASR:
                begin
                    // sign bit fills the vacated top bits
                    shifted      = $signed(operand) >>> shift_len;
                    carry_update = 1'b1;
                    carry_out    = operand[len_less_one[`ROT_W-1:0]];
                    if (len_full)
                    begin
                        shifted = `WORD_ZERO;
                    end
                    if (len_carry_off)
                    begin
                        carry_out = 1'b0;
                    end
                end
                `OP_LSR:
                begin
                    // zeros fill the vacated top bits
                    shifted      = operand >> shift_len;
                    carry_update = 1'b1;
                    carry_out    = operand[len_less_one[`ROT_W-1:0]];
                    if (len_full)
                    begin
                        shifted = `WORD_ZERO;
                    end
                    if (len_carry_off)
                    begin
                        carry_out = 1'b0;
                    end
                end
                `OP_LSL:
                begin
                    // zeros fill the vacated bottom bits, no overflow kept
                    shifted      = operand << shift_len;
                    carry_update = 1'b1;
                    // bit 32-n is bit 31 of the value shifted by n-1
                    carry_out    = operand[~len_less_one[`ROT_W-1:0]];
                    if (len_full)
                    begin
                        shifted = `WORD_ZERO;
                    end
                    if (len_carry_off)
                    begin
                        carry_out = 1'b0;
                    end
                end
                `OP_ROR:
                begin
                    carry_update = 1'b1;
                    if (rot_len == `ROT_ZERO)
                    begin
                        // multiples of 32: value kept, carry from bit 31
                        shifted   = operand;
                        carry_out = operand[`SIGN_BIT];
                    end
                    else
                    begin
                        // low n bits wrap into the top n positions
                        shifted   = (operand >> rot_len)
                                  | (operand << (`ROT_FULL - {1'b0, rot_len}));
                        carry_out = operand[rot_less_one];
                    end
                end
                default:
                begin
                    // not a shift: nothing moves
                    shifted      = operand;
                    carry_update = 1'b0;
                end
            endcase
        end
    end

endmodule

// ---- shift_flag_unit_assertions.sv ----
/*
 * concurrent checks on the ports of the shift and flag datapath slice.
 * assumes one clock domain, synchronous active-low reset, one-cycle answers.
 */
`timescale 1ns/1ps
`include "shift_flag_defs.vh"

module shift_flag_checker
(
    input wire                clk_sys,
    input wire                rst_n,
    input wire                op_valid,
    input wire [`OP_W-1:0]    op_code,
    input wire                set_flags,
    input wire [`WORD_W-1:0]  operand_m,
    input wire [`WORD_W-1:0]  operand_n,
    input wire [`SHAMT_W-1:0] shift_len,
    input wire [`WORD_W-1:0]  return_addr,
    input wire                flags_load,
    input wire [3:0]          flags_in,
    input wire [`WORD_W-1:0]  result,
    input wire                result_write,
    input wire [`WORD_W-1:0]  store_data,
    input wire [3:0]          store_strobe,
    input wire                store_write,
    input wire [`WORD_W-1:0]  link_value,
    input wire                link_write,
    input wire [`WORD_W-1:0]  branch_target,
    input wire                branch_write,
    input wire                branch_state_fault,
    input wire                flag_n,
    input wire                flag_z,
    input wire                flag_c,
    input wire                flag_v
);
    // ----------------------------------------------------------------
    // cause terms
    // ----------------------------------------------------------------
    wire take      = op_valid && !flags_load;                   // op accepted
    wire shift_op  = op_code >= `OP_ASR && op_code <= `OP_ROR;  // any shift
    wire short_len = shift_len != `SHAMT_ZERO && shift_len < `SHAMT_FULL;
    wire low_bit   = operand_m[shift_len - 8'h01];              // bit n-1
    wire top_bit   = operand_m[8'h20 - shift_len];              // bit 32-n
    wire rot_bit   = operand_m[shift_len[4:0] - 5'h01];         // last rotated bit
    wire and_zero  = (operand_m & operand_n) == `WORD_ZERO;     // and-test zero
    wire and_neg   = operand_m[31] & operand_n[31];             // and-test sign
    wire fault_in  = take && !operand_m[0] && (op_code == `OP_BRANCH_IND || op_code == `OP_BRANCH_IND_L);

    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    zero_len_a: assert property (
        take && shift_op && shift_len == `SHAMT_ZERO |=> result == $past(operand_m) && $stable(flag_c))
        else $error("zero length shift altered value or carry");
    sign_fill_a: assert property (
        take && op_code == `OP_ASR && short_len
            |=> $signed(result) == ($signed($past(operand_m)) >>> $past(shift_len)))
        else $error("arithmetic shift result wrong");
    right_carry_a: assert property (
        take && set_flags && (op_code == `OP_ASR || op_code == `OP_LSR) && short_len |=> flag_c == $past(low_bit))
        else $error("right shift carry wrong");
    big_shift_a: assert property (
        take && shift_op && op_code != `OP_ROR && shift_len >= `SHAMT_FULL |=> result == `WORD_ZERO)
        else $error("long shift result not zero");
    carry_off_a: assert property (
        take && set_flags && shift_op && op_code != `OP_ROR && shift_len >= `SHAMT_CARRY_OFF |=> !flag_c)
        else $error("long shift carry not zero");
    left_carry_a: assert property (
        take && set_flags && op_code == `OP_LSL && short_len |=> flag_c == $past(top_bit))
        else $error("left shift carry wrong");
    rot_carry_a: assert property (
        take && set_flags && op_code == `OP_ROR && shift_len[4:0] != `ROT_ZERO |=> flag_c == $past(rot_bit))
        else $error("rotate carry wrong");
    and_flags_a: assert property (
        take && op_code == `OP_AND_TEST |=> flag_z == $past(and_zero) && flag_n == $past(and_neg)
            && $stable(flag_c) && $stable(flag_v))
        else $error("and-test flags wrong");
    link_bit_a: assert property (
        link_write |-> link_value == ($past(return_addr) | `LINK_BIT0))
        else $error("link value bit0 not forced");
    fault_pulse_a: assert property (
        $past(rst_n) |-> branch_state_fault == $past(fault_in))
        else $error("branch fault pulse wrong");
    store_lane_a: assert property (
        store_write |-> store_data
            == ($past(operand_m) & ($past(op_code) == `OP_STORE_BYTE ? `BYTE_MASK : `HALF_MASK)))
        else $error("narrow store data wrong");
    v_hold_a: assert property (
        !flags_load |=> $stable(flag_v))
        else $error("overflow flag changed");
endmodule

bind shift_flag_unit shift_flag_checker chk (.clk_sys, .rst_n, .op_valid, .op_code, .set_flags, .operand_m,
    .operand_n, .shift_len, .return_addr, .flags_load, .flags_in, .result, .result_write, .store_data,
    .store_strobe, .store_write, .link_value, .link_write, .branch_target, .branch_write,
    .branch_state_fault, .flag_n, .flag_z, .flag_c, .flag_v);

// ---- testbench.sv ----
/*
 * self-checking bench for shift_flag_unit: shift sweep, and-test, extends,
 * narrow stores and branch/link ops. assumes one-cycle registered answers.
 */
`timescale 1ns/1ps
`include "shift_flag_defs.vh"

module testbench;
    reg         clk_sys     = 1'b0;
    reg         rst_n       = 1'b0;
    reg         op_valid    = 1'b0;
    reg         set_flags   = 1'b0;
    reg         flags_load  = 1'b0;
    reg  [3:0]  op_code     = 4'h0;
    reg  [3:0]  flags_in    = 4'h0;
    reg  [7:0]  shift_len   = 8'h00;
    reg  [31:0] operand_m   = 32'h0000_0000;
    reg  [31:0] operand_n   = 32'h0000_0000;
    reg  [31:0] return_addr = 32'h0000_0000;
    wire [31:0] result, store_data, link_value, branch_target;
    wire [3:0]  store_strobe;
    wire        result_write, store_write, link_write, branch_write, branch_state_fault;
    wire        flag_n, flag_z, flag_c, flag_v;
    wire [3:0]  flags       = {flag_n, flag_z, flag_c, flag_v};
    integer     error_cnt   = 0;
    integer     n_checks    = 0;
    integer     cycles      = 0;
    integer     op_i, li;
    reg  [32:0] e;
    reg  [31:0] m;
    reg  [7:0]  len_v;
    reg  [3:0]  fl;
    localparam [63:0] LENS  = 64'h0001_051f_2021_28ff; // 0,1,5,31,32,33,40,255

    always #20 clk_sys = ~clk_sys;

    shift_flag_unit dut (.clk_sys, .rst_n, .op_valid, .op_code, .set_flags, .operand_m, .operand_n,
        .shift_len, .return_addr, .flags_load, .flags_in, .result, .result_write, .store_data,
        .store_strobe, .store_write, .link_value, .link_write, .branch_target, .branch_write,
        .branch_state_fault, .flag_n, .flag_z, .flag_c, .flag_v);

    // expected {carry, result} of a shift
    function [32:0] ref_shift(input [3:0] op, input [31:0] v, input [7:0] len, input c_old);
        reg [4:0] r;
    begin
        r = len[4:0];
        if (len == 8'h00)
            ref_shift = {c_old, v};
        else if (op == `OP_ROR)
            ref_shift = (r == 5'h00) ? {v[31], v} : {v[r - 5'h01], (v >> r) | (v << (6'h20 - r))};
        else if (len > 8'h20)
            ref_shift = {1'b0, 32'h0000_0000};
        else if (len == 8'h20)
            ref_shift = {(op == `OP_LSL) ? v[0] : v[31], 32'h0000_0000};
        else if (op == `OP_ASR)
            ref_shift = {v[len - 8'h01], $signed(v) >>> len};
        else if (op == `OP_LSR)
            ref_shift = {v[len - 8'h01], v >> len};
        else
            ref_shift = {v[8'h20 - len], v << len};
    end
    endfunction

    // compare and count
    task check(input [31:0] seen, input [31:0] expected);
    begin
        n_checks = n_checks + 1;
        if (seen !== expected)
        begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, expected);
        end
    end
    endtask

    // one-cycle instruction; returns with the answer settled
    task run_op(input [3:0] op, input sf, input [31:0] am, input [31:0] an, input [7:0] len);
    begin
        @(posedge clk_sys);
        #1;
        op_valid = 1'b1;
        op_code = op;
        set_flags = sf;
        operand_m = am;
        operand_n = an;
        shift_len = len;
        @(posedge clk_sys);
        #1;
        op_valid = 1'b0;
    end
    endtask

    // preset the flags through the restore path
    task load_flags(input [3:0] f);
    begin
        @(posedge clk_sys);
        #1;
        flags_load = 1'b1;
        flags_in = f;
        @(posedge clk_sys);
        #1;
        flags_load = 1'b0;
    end
    endtask

    task print_verdict;
    begin
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask

    // cycle ceiling against a hang
    always @(posedge clk_sys)
    begin
        cycles = cycles + 1;
        if (cycles == 4000)
        begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH t=%0t run timed out", $time);
            print_verdict;
        end
    end

    initial
    begin
        repeat (6) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        // all four shifts, edge lengths, plain and flagged
        for (op_i = 1; op_i <= 4; op_i = op_i + 1)
        begin
            for (li = 0; li < 16; li = li + 1)
            begin
                m = li[0] ? 32'h4000_0003 : 32'h8c00_00f1;
                fl = {2'b01, ~li[1], 1'b1};
                len_v = LENS[63 - 8 * li[2:0] -: 8];
                load_flags(fl);
                e = ref_shift(op_i[3:0], m, len_v, fl[1]);
                run_op(op_i[3:0], li[3], m, 32'h0000_0000, len_v);
                check(result, e[31:0]);
                check({31'h0, result_write}, 32'h0000_0001);
                if (li[3])
                    fl = {e[31], e[31:0] == 32'h0, e[32], 1'b1};
                check({28'h0, flags}, {28'h0, fl});
            end
        end
        $display("shift sweep done");
        // and-test, zero extends, narrow stores keep c and v
        load_flags(4'b0110);
        run_op(`OP_AND_TEST, 1'b0, 32'hf0f0_0000, 32'h8000_ffff, 8'h00);
        check({28'h0, flags}, 32'h0000_000a);
        check({31'h0, result_write}, 32'h0000_0000);
        run_op(`OP_AND_TEST, 1'b0, 32'h0f0f_0000, 32'hf0f0_ffff, 8'h00);
        check({28'h0, flags}, 32'h0000_0006);
        run_op(`OP_ZEXT_BYTE, 1'b0, 32'hdead_beef, 32'h0000_0000, 8'h00);
        check(result, 32'h0000_00ef);
        run_op(`OP_ZEXT_HALF, 1'b0, 32'hdead_beef, 32'h0000_0000, 8'h00);
        check(result, 32'h0000_beef);
        run_op(`OP_STORE_BYTE, 1'b0, 32'h1234_5678, 32'h0000_0000, 8'h00);
        check(store_data, 32'h0000_0078);
        check({27'h0, store_write, store_strobe}, 32'h0000_0011);
        run_op(`OP_STORE_HALF, 1'b0, 32'h1234_5678, 32'h0000_0000, 8'h00);
        check(store_data, 32'h0000_5678);
        check({27'h0, store_write, store_strobe}, 32'h0000_0013);
        check({28'h0, flags}, 32'h0000_0006);
        run_op(`OP_NONE, 1'b1, 32'hffff_ffff, 32'hffff_ffff, 8'h01);
        check({27'h0, result_write, flags}, 32'h0000_0006);
        $display("flag and store tests done");
        // link and indirect branches
        return_addr = 32'h0000_0200;
        run_op(`OP_BRANCH_LINK, 1'b0, 32'h0000_0000, 32'h0000_0000, 8'h00);
        check(link_value, 32'h0000_0201);
        check({30'h0, link_write, branch_write}, 32'h0000_0002);
        run_op(`OP_BRANCH_IND, 1'b0, 32'h0000_0101, 32'h0000_0000, 8'h00);
        check(branch_target, 32'h0000_0101);
        check({29'h0, link_write, branch_write, branch_state_fault}, 32'h0000_0002);
        return_addr = 32'h0000_0300;
        run_op(`OP_BRANCH_IND_L, 1'b0, 32'h0000_0100, 32'h0000_0000, 8'h00);
        check(link_value, 32'h0000_0301);
        check({29'h0, link_write, branch_write, branch_state_fault}, 32'h0000_0007);
        $display("branch tests done");
        print_verdict;
    end
endmodule
